// ---- hw/wwc_pkg.sv ----
// Operation
// R01: Closed window is timed in slow watchdog clock cycles from the period field.
// R02: Code 0000 gives 8 cycles, each code doubles, up to 8K at 1010.
// R03: Codes 1011 through 1111 give no closed-window timeout.
// R04: Closed-window period field loads from the window-period fuses at power-on.
// R05: With window mode off, only the open timeout period governs expiry.
// R06: Window fields change only when the same write sets the change-allow bit.
// R07: Window mode runs while bit 1 of the window control register is set.
// R08: Window control writes are accepted only inside the timed protection sequence.
// R09: Window change-allow stays writable under the lock fuse.
// R10: Busy flag, status bit 0, sets on control writes being synchronised.
// R11: Busy flag clears by itself once synchronisation completes.
// R12: Synchronisation happens only while the watchdog enable bit is set.
// R13: Software writes zeros into status bits 7 through 1.
// R14: Service during the closed window requests a system reset.
// R15: Open window always follows the closed window; timeout is their sum.
// R16: Watchdog counts on a one-kilohertz tick independent of the bus clock. The code derives its tick from i_clock through the TICK_DIV divider.
// R17: Lock fuse blocks closed-period changes but lets window mode toggle.
// R18: Each service restarts the closed count, then the open count.
package wwc_pkg;
	localparam int CLK_PERIOD_NS = 5;
	localparam int SLOW_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES = SLOW_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SYNC_TICKS = 2;
	localparam int CCP_OPEN_CYCLES = 4;
	// Key value is arbitrary
	localparam logic [7:0] CCP_KEY = 8'h96;
	localparam int ADDR_W = 5;
	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_WINDOW_MODE_CONTROL = 3'h1;
	localparam logic [2:0] IDX_STATUS = 3'h2;
	localparam logic [2:0] IDX_CCP = 3'h3;
	localparam int BIT_CHG = 0;
	localparam int BIT_EN = 1;
	localparam int PER_LSB = 2;
	localparam int PER_W = 4;
	localparam int BIT_BUSY = 0;
	localparam int CNT_W = 14;
	localparam logic [PER_W-1:0] MAX_CODE = 4'ha;
	localparam logic [CNT_W-1:0] BASE_CYCLES = 14'h0008;
	typedef enum logic [1:0] {PH_IDLE, PH_CLOSED, PH_OPEN} wwc_phase_t;
endpackage

// ---- hw/wwc_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module wwc_timer (
	input wire logic i_clock, // System clock
	input wire logic i_rst_b, // Synchronous reset, active low
	wwc_tmr_if.tmr t // Settings in, reset request out
);
	import wwc_pkg::*;
	typedef struct packed {
		wwc_phase_t phase;
		logic [CNT_W-1:0] cnt;
		logic req;
	} wwc_tmr_t;
	wwc_tmr_t st_q, st_d;
	logic closed_ok, open_ok;
	logic [CNT_W-1:0] closed_len, open_len, cnt_inc;
	wwc_phase_t start_ph;

	// Window lengths; reserved codes disable their timeout
	always_comb begin
		closed_ok = t.win_en && (t.closed_code <= MAX_CODE); // R03 R05 R07
		open_ok = t.open_code <= MAX_CODE;
		closed_len = BASE_CYCLES << t.closed_code; // R01 R02
		open_len = BASE_CYCLES << t.open_code;
		start_ph = closed_ok ? PH_CLOSED : PH_OPEN; // R18
		cnt_inc = st_q.cnt + 14'h0001;
	end

	// Phase sequencing; counts advance only on slow ticks
	always_comb begin
		st_d = st_q;
		if (!t.enable) begin
			st_d.phase = PH_IDLE;
			st_d.cnt = '0;
		end else if (t.service) begin
			if (st_q.phase == PH_CLOSED) begin
				st_d.req = 1'b1; // R14
			end
			st_d.phase = start_ph; // R18
			st_d.cnt = '0;
		end else if (st_q.phase == PH_IDLE) begin
			st_d.phase = start_ph;
			st_d.cnt = '0;
		end else if (t.tick) begin // R16
			st_d.cnt = cnt_inc;
			if (st_q.phase == PH_CLOSED && cnt_inc >= closed_len) begin
				st_d.phase = PH_OPEN; // R15
				st_d.cnt = '0;
			end else if (st_q.phase == PH_OPEN && open_ok && cnt_inc >= open_len) begin
				st_d.req = 1'b1; // R05
			end
		end
	end

	// Request stays until system reset so it cannot be missed
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			st_q <= '{phase: PH_IDLE, cnt: '0, req: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end
	assign t.reset_req = st_q.req;

	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	early_service_a: assert property (t.enable && t.service && st_q.phase == PH_CLOSED // R14
		|=> t.reset_req) else $error("early service gave no reset");
	req_sticky_a: assert property (t.reset_req |=> t.reset_req)
		else $error("reset request dropped");
	closed_first_a: assert property (t.enable && t.service && closed_ok // R18
		|=> st_q.phase == PH_CLOSED && st_q.cnt == 14'h0000)
		else $error("service did not restart closed window");
	open_follow_a: assert property (st_q.phase == PH_OPEN && !$past(t.service) // R15
		&& $past(st_q.phase) != PH_IDLE && t.enable && $past(t.enable)
		|-> $past(st_q.phase) inside {PH_OPEN, PH_CLOSED}) else $error("open not after closed");
	reserved_code_a: assert property (t.enable && t.closed_code > MAX_CODE && !t.service // R03
		&& st_q.phase == PH_OPEN |=> st_q.phase != PH_CLOSED) else $error("reserved code timed");
endmodule
`default_nettype wire

// ---- hw/wwc_tmr_if.sv ----
`timescale 1ns/10ps
`default_nettype none
// Carries applied settings into the timer and its reset request back out
interface wwc_tmr_if;
	import wwc_pkg::*;
	logic tick;
	logic enable;
	logic win_en;
	logic [PER_W-1:0] closed_code;
	logic [PER_W-1:0] open_code;
	logic service;
	logic reset_req;
	modport ctl(output tick, enable, win_en, closed_code, open_code, service, input reset_req);
	modport tmr(input tick, enable, win_en, closed_code, open_code, service, output reset_req);
endinterface
`default_nettype wire

// ---- hw/wwc_top.sv ----
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module wwc_top #(
	parameter int TICK_DIV = wwc_pkg::TICK_CYCLES // Bus cycles per watchdog tick
) (
	input wire logic i_clock, // 200 MHz system clock
	input wire logic i_rst_b, // Synchronous reset, active low
	input wire logic [wwc_pkg::ADDR_W-1:0] i_address, // Avalon byte address
	input wire logic i_read, // Avalon read
	input wire logic i_write, // Avalon write
	input wire logic [31:0] i_writedata, // Avalon write data
	input wire logic [3:0] i_byteenable, // Avalon byte enables
	output logic [31:0] o_readdata, // Avalon read data
	output logic o_waitrequest, // Avalon wait request
	input wire logic [wwc_pkg::PER_W-1:0] i_fuse_open_period, // Open period fuses
	input wire logic [wwc_pkg::PER_W-1:0] i_window_period_fuses, // Closed period fuses
	input wire logic i_fuse_enable, // Enable fuse
	input wire logic i_lock_fuse, // Watchdog lock fuse
	input wire logic i_service, // Service instruction pulse
	output logic o_reset_req // System reset request
);
	import wwc_pkg::*;
	localparam int DIV_W = $clog2(TICK_DIV + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
	localparam logic [1:0] SYNC_LAST = 2'(SYNC_TICKS - 1);
	localparam logic [2:0] CCP_LOAD = 3'(CCP_OPEN_CYCLES);

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [PER_W-1:0] open_timeout_period;
		logic en;
		logic [PER_W-1:0] closed_window_period;
		logic wen;
		logic [PER_W-1:0] a_per;
		logic a_en;
		logic [PER_W-1:0] a_closed_window_period;
		logic a_wen;
		logic busy;
		logic [1:0] sync_cnt;
		logic [2:0] ccp_cnt;
		logic [DIV_W-1:0] div;
		logic tick;
	} wwc_ctl_t;
	wwc_ctl_t st_q, st_d;
	wwc_tmr_if tif();
	logic [2:0] idx;
	logic wr_go, prot, ctrl_ok, win_ok;
	logic [7:0] wd;

	// Timer sees only settings that have reached the slow domain
	assign tif.tick = st_q.tick;
	assign tif.enable = st_q.a_en;
	assign tif.win_en = st_q.a_wen;
	assign tif.closed_code = st_q.a_closed_window_period;
	assign tif.open_code = st_q.a_per;
	assign tif.service = i_service;

	wwc_timer u_timer (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.t(tif.tmr)
	);

	// Write qualification; lane 0 holds all eight register bits
	always_comb begin
		idx = i_address[ADDR_W-1:2];
		wd = i_writedata[7:0];
		wr_go = st_q.ack && i_write && i_byteenable[0];
		prot = st_q.ccp_cnt != 3'h0; // R08
		ctrl_ok = wr_go && idx == IDX_CTRL && prot && !i_lock_fuse && wd[BIT_CHG];
		win_ok = wr_go && idx == IDX_WINDOW_MODE_CONTROL && prot && wd[BIT_CHG]; // R06 R08 R09
	end

	// Bus slave, protection window, divider and synchroniser
	always_comb begin
		st_d = st_q;
		// One wait state: answer lands the cycle after the request is seen
		st_d.ack = (i_read || i_write) && !st_q.ack;
		if ((i_read || i_write) && !st_q.ack) begin
			case (idx)
				IDX_CTRL: st_d.rdata = {24'h0, 2'h0, st_q.open_timeout_period, st_q.en, 1'b0};
				IDX_WINDOW_MODE_CONTROL: st_d.rdata = {24'h0, 2'h0, st_q.closed_window_period, st_q.wen, 1'b0};
				IDX_STATUS: st_d.rdata = {31'h0, st_q.busy}; // R10
				default: st_d.rdata = 32'h0;
			endcase
		end
		// Key opens a short window for protected writes
		if (st_q.ccp_cnt != 3'h0) begin
			st_d.ccp_cnt = st_q.ccp_cnt - 3'h1;
		end
		if (wr_go && idx == IDX_CCP && wd == CCP_KEY) begin
			st_d.ccp_cnt = CCP_LOAD; // R08
		end
		if (ctrl_ok) begin
			st_d.open_timeout_period = wd[PER_LSB +: PER_W];
			st_d.en = wd[BIT_EN];
		end
		if (win_ok) begin
			st_d.wen = wd[BIT_EN]; // R07 R17
			if (!i_lock_fuse) begin
				st_d.closed_window_period = wd[PER_LSB +: PER_W]; // R17
			end
		end
		// Slow tick divider
		st_d.tick = 1'b0;
		if (st_q.div == DIV_LAST) begin
			st_d.div = '0;
			st_d.tick = 1'b1; // R16
		end else begin
			st_d.div = st_q.div + DIV_W'(1);
		end
		// Crossing into the slow domain lasts a fixed number of ticks
		if (!st_d.en) begin
			st_d.busy = 1'b0; // R12
			st_d.sync_cnt = 2'h0;
			st_d.a_en = 1'b0;
			st_d.a_per = st_d.open_timeout_period;
			st_d.a_closed_window_period = st_d.closed_window_period;
			st_d.a_wen = st_d.wen;
		end else if (ctrl_ok || win_ok) begin
			st_d.busy = 1'b1; // R10
			st_d.sync_cnt = 2'h0;
		end else if (st_q.busy && st_q.tick) begin
			if (st_q.sync_cnt == SYNC_LAST) begin
				st_d.busy = 1'b0; // R11
				st_d.a_en = st_q.en;
				st_d.a_per = st_q.open_timeout_period;
				st_d.a_closed_window_period = st_q.closed_window_period;
				st_d.a_wen = st_q.wen;
			end else begin
				st_d.sync_cnt = st_q.sync_cnt + 2'h1;
			end
		end
	end

	// Fuse values land at reset, so the first watchdog period is fused
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			st_q <= '0;
			st_q.open_timeout_period <= i_fuse_open_period;
			st_q.a_per <= i_fuse_open_period;
			st_q.closed_window_period <= i_window_period_fuses; // R04
			st_q.a_closed_window_period <= i_window_period_fuses; // R04
			st_q.en <= i_fuse_enable;
			st_q.a_en <= i_fuse_enable;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flops
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_waitrequest <= 1'b1;
			o_reset_req <= 1'b0;
		end else begin
			o_waitrequest <= !st_d.ack;
			o_reset_req <= tif.reset_req;
		end
	end
	assign o_readdata = st_q.rdata;

	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	wait_answer_a: assert property ((i_read || i_write) && o_waitrequest && !st_q.ack
		|=> !o_waitrequest) else $error("no answer after one wait state");
	wait_single_a: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("answer held too long");
	busy_set_a: assert property ((ctrl_ok && wd[BIT_EN]) || (win_ok && st_q.en) // R10
		|=> st_q.busy) else $error("busy not set on write");
	busy_clear_a: assert property ($fell(st_q.busy) && st_q.en |-> $past(st_q.tick)) // R11
		else $error("busy cleared without a tick");
	busy_bound_a: assert property ($rose(st_q.busy) && TICK_DIV < 300 // R11
		|-> ##[1:900] !st_q.busy) else $error("busy never cleared");
	no_sync_off_a: assert property (!st_q.en |-> !st_q.busy) // R12
		else $error("sync while disabled");
	lock_period_a: assert property (i_lock_fuse && $past(i_lock_fuse) // R17
		|-> $stable(st_q.closed_window_period) && $stable(st_q.open_timeout_period)) else $error("locked period changed");
	no_key_a: assert property (st_q.ccp_cnt == 3'h0 // R08
		|=> $stable(st_q.wen) && $stable(st_q.closed_window_period)) else $error("unprotected window write");
	need_chg_a: assert property (wr_go && idx == IDX_WINDOW_MODE_CONTROL && !wd[BIT_CHG] // R06
		|=> $stable(st_q.wen)) else $error("write without change-allow");
endmodule
`default_nettype wire

// ---- sim/wwc_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin errors++; $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module wwc_bench;
	import wwc_pkg::*;
	localparam int TDIV = 4;
	logic i_clock = 1'b0;
	logic i_rst_b = 1'b0;
	logic [ADDR_W-1:0] i_address = '0;
	logic i_read = 1'b0;
	logic i_write = 1'b0;
	logic [31:0] i_writedata = '0;
	logic [3:0] i_byteenable = 4'h1;
	logic [31:0] o_readdata;
	logic o_waitrequest;
	logic [PER_W-1:0] i_fuse_open_period = 4'hb;
	logic [PER_W-1:0] i_window_period_fuses = 4'h0;
	logic i_fuse_enable = 1'b1;
	logic i_lock_fuse = 1'b0;
	logic i_service = 1'b0;
	logic o_reset_req;
	int errors = 0;
	int comparisons = 0;
	int hits;
	int exp_hits = 0;
	int mc;
	int mw;
	bit key;
	logic [31:0] q;
	always #2.5 i_clock = ~i_clock;
	wwc_top #(.TICK_DIV(TDIV)) dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
		.i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
		.i_fuse_open_period(i_fuse_open_period), .i_window_period_fuses(i_window_period_fuses),
		.i_fuse_enable(i_fuse_enable), .i_lock_fuse(i_lock_fuse), .i_service(i_service),
		.o_reset_req(o_reset_req));
	wwc_sys_rst sysrst (.i_clock(i_clock), .i_req(o_reset_req), .o_hits(hits));
	task automatic wrap_up();
		$display("Comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Drops any held request, then lets n edges pass
	task automatic cyc(input int n);
		i_write <= 1'b0;
		i_read <= 1'b0;
		repeat (n) @(posedge i_clock);
	endtask
	// One transfer; strobe left up so a following one runs back to back
	task automatic bus(input bit wr, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		i_address <= a;
		i_writedata <= {24'h0, d};
		i_write <= wr;
		i_read <= !wr;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_waitrequest !== 1'b0 && n < 40);
		q = o_readdata;
		if (n >= 40) begin
			errors++;
			$display("Error waitrequest expected 0 seen %0h", o_waitrequest);
		end
		// Reference register model
		if (wr && a == 5'h00 && key && d[0] && !i_lock_fuse) mc = d & 8'h3e;
		if (wr && a == 5'h04 && key && d[0]) mw = i_lock_fuse ? (mw & 8'h3c) | (d & 8'h02) : d & 8'h3e;
		key = wr && a == 5'h0c && d == CCP_KEY;
	endtask
	task automatic rd(input logic [4:0] a, input int ex);
		bus(1'b0, a, 8'h00);
		`CHK("readdata", ex[31:0], q)
	endtask
	task automatic rst(input logic [3:0] op, input logic [3:0] wp, input bit en, input bit lk);
		i_rst_b <= 1'b0;
		i_fuse_open_period <= op;
		i_window_period_fuses <= wp;
		i_fuse_enable <= en;
		i_lock_fuse <= lk;
		cyc(20);
		i_rst_b <= 1'b1;
		@(posedge i_clock);
		mc = {op, en, 1'b0};
		mw = {wp, 2'b00};
		key = 0;
	endtask
	task automatic svc();
		i_service <= 1'b1;
		@(posedge i_clock);
		i_service <= 1'b0;
	endtask
	// Window run: service, wait gap, service again, then look for a reset request
	task automatic probe(input logic [3:0] c, input int gap, input bit ex);
		int n;
		rst(4'hb, c, 1'b1, 1'b0);
		rd(5'h04, mw);
		bus(1'b1, 5'h0c, CCP_KEY);
		bus(1'b1, 5'h04, {2'b00, c, 2'b11});
		rd(5'h08, 1);
		n = 0;
		do begin
			bus(1'b0, 5'h08, 8'h00);
			n++;
		end while (q[0] !== 1'b0 && n < 20);
		`CHK("busy", 1'b0, q[0])
		rd(5'h04, mw);
		cyc(2);
		svc();
		cyc(gap);
		svc();
		cyc(6);
		`CHK("reset_req", ex, o_reset_req)
		exp_hits += ex;
	endtask
	initial begin
		int c;
		void'($urandom(68811));
		c = $urandom % 11;
		// Register path, unmapped places and refused writes
		rst(4'h0, c[3:0], 1'b1, 1'b0);
		rd(5'h00, mc);
		rd(5'h08, 0);
		bus(1'b1, 5'h04, 8'h07);
		bus(1'b1, 5'h0c, CCP_KEY);
		bus(1'b1, 5'h04, 8'h06);
		bus(1'b1, 5'h08, 8'h00);
		bus(1'b1, 5'h18, 8'hff);
		rd(5'h04, mw);
		rd(5'h14, 0);
		// Window off: closed period ignored, open period alone expires
		cyc(1);
		svc();
		cyc(4);
		svc();
		cyc(20);
		`CHK("reset_req", 1'b0, o_reset_req)
		cyc(24);
		`CHK("reset_req", 1'b1, o_reset_req)
		exp_hits++;
		// Watchdog off: no synchronisation, values apply at once
		rst(4'hb, 4'h2, 1'b0, 1'b0);
		bus(1'b1, 5'h0c, CCP_KEY);
		bus(1'b1, 5'h04, 8'h0b);
		rd(5'h08, 0);
		rd(5'h04, mw);
		// Enabling write starts a synchronisation
		bus(1'b1, 5'h0c, CCP_KEY);
		bus(1'b1, 5'h00, 8'h2f);
		rd(5'h08, 1);
		rd(5'h00, mc);
		// Lock fuse: period held, window mode and change-allow still work
		rst(4'hb, 4'h3, 1'b1, 1'b1);
		bus(1'b1, 5'h0c, CCP_KEY);
		bus(1'b1, 5'h04, 8'h17);
		bus(1'b1, 5'h0c, CCP_KEY);
		bus(1'b1, 5'h00, 8'h01);
		rd(5'h04, mw);
		rd(5'h00, mc);
		probe(4'h0, 2, 1'b1);
		for (int i = 0; i < 4; i++) begin
			c = $urandom % 4;
			probe(c[3:0], (8 << c) * TDIV - 12, 1'b1);
			probe(c[3:0], (8 << c) * TDIV + 12, 1'b0);
		end
		probe(4'(4'hb + $urandom % 5), 4, 1'b0);
		probe(MAX_CODE, 8192 * TDIV - 12, 1'b1);
		cyc(4);
		`CHK("requests", exp_hits, hits)
		wrap_up();
	end
	// Longest probe is about 33k cycles
	initial begin
		repeat (60000) @(posedge i_clock);
		errors++;
		wrap_up();
	end
endmodule
`default_nettype wire

// ---- sim/wwc_sys_rst.sv ----
`timescale 1ns/10ps
`default_nettype none
// Reset controller stand-in; counts new requests, since the request is sticky
module wwc_sys_rst (
	input wire logic i_clock, // System clock
	input wire logic i_req, // Reset request from the watchdog
	output int o_hits // Requests seen so far
);
	logic req_q = 1'b0;
	int hit_cnt = 0;
	assign o_hits = hit_cnt;
	// Rising request edges only
	always @(posedge i_clock) begin
		req_q <= i_req;
		if (i_req === 1'b1 && req_q !== 1'b1) begin
			hit_cnt <= hit_cnt + 1;
		end
	end
endmodule
`default_nettype wire
